//--- rtl/asf_pkg.sv
package asf_pkg;

   // ----------------------------------------------------------------
   // bit timing and receive buffer depth
   // ----------------------------------------------------------------
   localparam logic [3:0]  OS_LAST   = 4'hF;
   localparam logic [3:0]  OS_MID    = 4'h7;
   localparam logic [3:0]  OS_FIRST  = 4'h0;
   localparam logic [3:0]  LAST_BIT8 = 4'h7;
   localparam logic [3:0]  LAST_BIT9 = 4'h8;
   localparam logic [15:0] BRG_RESET = 16'h0000;
   localparam logic [1:0]  BUF_DEPTH = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        spen;
      logic        tx_en;
      logic        rx_en;
      logic        nine_bit;
      logic        addr_det;
      logic        brg16;
      logic [15:0] brg_div;
   } asf_cfg_t;

   typedef struct packed {
      logic       ferr;
      logic [8:0] data;
   } asf_rx_char_t;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_START = 4'h2,
      TX_DATA  = 4'h4,
      TX_STOP  = 4'h8
   } asf_tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'h1,
      RX_START = 4'h2,
      RX_DATA  = 4'h4,
      RX_STOP  = 4'h8
   } asf_rx_state_t;

endpackage : asf_pkg

//--- rtl/asf_baud.sv
module asf_baud (
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   input  wire logic        run_in,
   input  wire logic        brg16_in,
   input  wire logic [15:0] div_in,
   output logic             tick_out
);

   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } asf_baud_st_t;

   asf_baud_st_t st;
   asf_baud_st_t next_st;
   logic [15:0]  reload;

   // ----------------------------------------------------------------
   // divider: 8-bit or 16-bit reload, one tick per sixteenth bit
   // ----------------------------------------------------------------
   always_comb begin
      reload  = brg16_in ? div_in : {8'h00, div_in[7:0]};
      next_st = st;
      next_st.tick = 1'b0;
      if (!run_in) begin
         next_st.cnt = reload;
      end else if (st.cnt == 16'h0000) begin
         next_st.cnt  = reload;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 16'h0001;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '{cnt: asf_pkg::BRG_RESET, tick: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign tick_out = st.tick;

endmodule : asf_baud

//--- rtl/asf_rxbuf.sv
module asf_rxbuf (
   input  wire logic                  mclk_in,
   input  wire logic                  resetn_in,
   input  wire logic                  flush_in,
   input  wire logic                  in_valid_in,
   input  wire asf_pkg::asf_rx_char_t in_data_in,
   output logic                       in_ready_out,
   output logic                       out_valid_out,
   output asf_pkg::asf_rx_char_t      out_data_out,
   input  wire logic                  out_ready_in
);

   typedef struct packed {
      asf_pkg::asf_rx_char_t slot0;
      asf_pkg::asf_rx_char_t slot1;
      logic [1:0]            cnt;
   } asf_rxbuf_st_t;

   asf_rxbuf_st_t st;
   asf_rxbuf_st_t next_st;
   logic          push;
   logic          pop;

   // ----------------------------------------------------------------
   // two entries, slot0 is the head
   // ----------------------------------------------------------------
   always_comb begin
      push    = in_valid_in && in_ready_out;
      pop     = out_valid_out && out_ready_in;
      next_st = st;
      if (flush_in) begin
         next_st.cnt = 2'h0;
      end else if (push && pop) begin
         if (st.cnt == 2'h1) begin
            next_st.slot0 = in_data_in;
         end else begin
            next_st.slot0 = st.slot1;
            next_st.slot1 = in_data_in;
         end
      end else if (pop) begin
         next_st.slot0 = st.slot1;
         next_st.cnt   = st.cnt - 2'h1;
      end else if (push) begin
         if (st.cnt == 2'h0) begin
            next_st.slot0 = in_data_in;
         end else begin
            next_st.slot1 = in_data_in;
         end
         next_st.cnt = st.cnt + 2'h1;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready_out  = (st.cnt != asf_pkg::BUF_DEPTH);
   assign out_valid_out = (st.cnt != 2'h0);
   assign out_data_out  = st.slot0;

endmodule : asf_rxbuf

//--- rtl/asf_uart.sv
module asf_uart (
   input  wire logic                  mclk_in,
   input  wire logic                  resetn_in,
   input  wire asf_pkg::asf_cfg_t     cfg_in,
   input  wire logic                  tx_write_in,
   input  wire logic [7:0]            tx_data_in,
   input  wire logic                  tx_ninth_bit_in,
   output logic                       tx_buffer_empty_flag_out,
   output logic                       shifter_empty_status_out,
   input  wire logic                  receive_line_pin_in,
   output logic                       transmit_line_pin_out,
   output logic                       transmit_line_pin_oe_out,
   output logic                       rx_valid_out,
   output asf_pkg::asf_rx_char_t      rx_char_out,
   input  wire logic                  rx_ready_in,
   output logic                       rx_overrun_out,
   input  wire logic                  rx_overrun_clr_in
);

   typedef struct packed {
      asf_pkg::asf_tx_state_t tx_state;
      logic [3:0]             tx_os;
      logic [3:0]             tx_bit;
      logic [8:0]             tx_shifter;
      logic                   tx_lead;
      logic                   tx_line;
      logic [8:0]             tx_holding_buffer;
      logic                   hold_valid;
      logic                   shifter_empty;
      asf_pkg::asf_rx_state_t rx_state;
      logic [3:0]             rx_os;
      logic [3:0]             rx_bit;
      logic [8:0]             rx_shift;
      logic                   rx_prev;
      logic                   overrun;
   } asf_uart_st_t;

   asf_uart_st_t          st;
   asf_uart_st_t          next_st;
   logic                  tick;
   logic                  tx_on;
   logic                  rx_on;
   logic [3:0]            last_bit;
   logic [8:0]            wr_char;
   logic                  push;
   logic                  push_ready;
   asf_pkg::asf_rx_char_t push_char;

   // ----------------------------------------------------------------
   // format decoding
   // ----------------------------------------------------------------
   // index of the last data bit of a character
   function automatic logic [3:0] last_data_bit(input logic nine);
      return nine ? asf_pkg::LAST_BIT9 : asf_pkg::LAST_BIT8;
   endfunction : last_data_bit

   // last oversample of a bit, where a bit is sampled or ends
   function automatic logic bit_end(input logic [3:0] os);
      return os == asf_pkg::OS_LAST;
   endfunction : bit_end

   // the ninth bit only exists in nine-bit mode
   function automatic logic [8:0] fit_char(input logic nine, input logic [8:0] raw);
      return {raw[8] & nine, raw[7:0]};
   endfunction : fit_char

   // an eight-bit character sits in the top of the shift register
   function automatic logic [8:0] align_rx(input logic nine, input logic [8:0] shift);
      return nine ? shift : {1'b0, shift[8:1]};
   endfunction : align_rx

   // in nine-bit address mode only characters with the ninth bit set are kept
   function automatic logic keep_rx(input asf_pkg::asf_cfg_t cfg, input logic [8:0] data);
      return !(cfg.nine_bit && cfg.addr_det && !data[8]);
   endfunction : keep_rx

   // ----------------------------------------------------------------
   // shared timing and format
   // ----------------------------------------------------------------
   assign tx_on    = cfg_in.spen && cfg_in.tx_en;
   assign rx_on    = cfg_in.spen && cfg_in.rx_en;
   assign last_bit = last_data_bit(cfg_in.nine_bit);
   assign wr_char  = fit_char(cfg_in.nine_bit, {tx_ninth_bit_in, tx_data_in});

   asf_baud u_baud (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .run_in    (cfg_in.spen),
      .brg16_in  (cfg_in.brg16),
      .div_in    (cfg_in.brg_div),
      .tick_out  (tick)
   );

   asf_rxbuf u_rxbuf (
      .mclk_in       (mclk_in),
      .resetn_in     (resetn_in),
      .flush_in      (!rx_on),
      .in_valid_in   (push),
      .in_data_in    (push_char),
      .in_ready_out  (push_ready),
      .out_valid_out (rx_valid_out),
      .out_data_out  (rx_char_out),
      .out_ready_in  (rx_ready_in)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st   = st;
      push      = 1'b0;
      push_char = '0;

      // ----------------------------------------------------------------
      // transmitter
      // ----------------------------------------------------------------
      if (!tx_on) begin
         next_st.tx_state      = asf_pkg::TX_IDLE;
         next_st.tx_line       = 1'b1;
         next_st.hold_valid    = 1'b0;
         next_st.shifter_empty = 1'b1;
         next_st.tx_lead       = 1'b0;
      end else begin
         case (st.tx_state)
            asf_pkg::TX_IDLE: begin
               next_st.tx_line = 1'b1;
               if (st.hold_valid || tx_write_in) begin
                  next_st.tx_shifter    = st.hold_valid ? st.tx_holding_buffer : wr_char;
                  next_st.hold_valid    = 1'b0;
                  next_st.shifter_empty = 1'b0;
                  next_st.tx_lead       = 1'b1;
                  next_st.tx_bit        = 4'h0;
                  next_st.tx_state      = asf_pkg::TX_START;
               end
            end
            asf_pkg::TX_START: begin
               if (tick) begin
                  if (st.tx_lead) begin
                     next_st.tx_lead = 1'b0;
                     next_st.tx_line = 1'b0;
                     next_st.tx_os   = asf_pkg::OS_FIRST;
                  end else if (bit_end(st.tx_os)) begin
                     next_st.tx_os    = asf_pkg::OS_FIRST;
                     next_st.tx_line  = st.tx_shifter[0];
                     next_st.tx_state = asf_pkg::TX_DATA;
                  end else begin
                     next_st.tx_os = st.tx_os + 4'h1;
                  end
               end
            end
            asf_pkg::TX_DATA: begin
               if (tick) begin
                  if (bit_end(st.tx_os)) begin
                     next_st.tx_os = asf_pkg::OS_FIRST;
                     if (st.tx_bit == last_bit) begin
                        next_st.tx_line  = 1'b1;
                        next_st.tx_state = asf_pkg::TX_STOP;
                     end else begin
                        next_st.tx_shifter = {1'b0, st.tx_shifter[8:1]};
                        next_st.tx_line    = st.tx_shifter[1];
                        next_st.tx_bit     = st.tx_bit + 4'h1;
                     end
                  end else begin
                     next_st.tx_os = st.tx_os + 4'h1;
                  end
               end
            end
            asf_pkg::TX_STOP: begin
               if (tick) begin
                  if (bit_end(st.tx_os)) begin
                     next_st.tx_os = asf_pkg::OS_FIRST;
                     if (st.hold_valid) begin
                        next_st.tx_shifter = st.tx_holding_buffer;
                        next_st.hold_valid = 1'b0;
                        next_st.tx_line    = 1'b0;
                        next_st.tx_bit     = 4'h0;
                        next_st.tx_state   = asf_pkg::TX_START;
                     end else begin
                        next_st.shifter_empty = 1'b1;
                        next_st.tx_state      = asf_pkg::TX_IDLE;
                     end
                  end else begin
                     next_st.tx_os = st.tx_os + 4'h1;
                  end
               end
            end
            default: begin
               next_st.tx_state = asf_pkg::TX_IDLE;
            end
         endcase
         // a write while the shifter is busy waits in the holding buffer if that is empty, else it is dropped
         if (tx_write_in && !st.hold_valid && st.tx_state != asf_pkg::TX_IDLE) begin
            next_st.tx_holding_buffer = wr_char;
            next_st.hold_valid        = 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // receiver
      // ----------------------------------------------------------------
      if (!rx_on) begin
         next_st.rx_state = asf_pkg::RX_IDLE;
         next_st.rx_prev  = 1'b0;
      end else if (tick) begin
         case (st.rx_state)
            asf_pkg::RX_IDLE: begin
               next_st.rx_prev = receive_line_pin_in;
               if (st.rx_prev && !receive_line_pin_in) begin
                  next_st.rx_os    = asf_pkg::OS_FIRST;
                  next_st.rx_state = asf_pkg::RX_START;
               end
            end
            asf_pkg::RX_START: begin
               if (st.rx_os == asf_pkg::OS_MID) begin
                  next_st.rx_os  = asf_pkg::OS_FIRST;
                  next_st.rx_bit = 4'h0;
                  // a start that is back at mark mid-bit was a glitch
                  next_st.rx_state = receive_line_pin_in ? asf_pkg::RX_IDLE
                                                         : asf_pkg::RX_DATA;
               end else begin
                  next_st.rx_os = st.rx_os + 4'h1;
               end
            end
            asf_pkg::RX_DATA: begin
               if (bit_end(st.rx_os)) begin
                  next_st.rx_os    = asf_pkg::OS_FIRST;
                  next_st.rx_shift = {receive_line_pin_in, st.rx_shift[8:1]};
                  next_st.rx_bit   = st.rx_bit + 4'h1;
                  if (st.rx_bit == last_bit) begin
                     next_st.rx_state = asf_pkg::RX_STOP;
                  end
               end else begin
                  next_st.rx_os = st.rx_os + 4'h1;
               end
            end
            asf_pkg::RX_STOP: begin
               if (bit_end(st.rx_os)) begin
                  push_char.ferr = !receive_line_pin_in;
                  push_char.data = align_rx(cfg_in.nine_bit, st.rx_shift);
                  push = keep_rx(cfg_in, push_char.data);
                  // a low stop must return to mark before the next start
                  next_st.rx_prev  = receive_line_pin_in;
                  next_st.rx_state = asf_pkg::RX_IDLE;
               end else begin
                  next_st.rx_os = st.rx_os + 4'h1;
               end
            end
            default: begin
               next_st.rx_state = asf_pkg::RX_IDLE;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // overrun
      // ----------------------------------------------------------------
      // a new event wins over a clear in the same cycle
      if (push && !push_ready) begin
         next_st.overrun = 1'b1;
      end else if (rx_overrun_clr_in) begin
         next_st.overrun = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st               <= '0;
         st.tx_state      <= asf_pkg::TX_IDLE;
         st.rx_state      <= asf_pkg::RX_IDLE;
         st.tx_line       <= 1'b1;
         st.shifter_empty <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign transmit_line_pin_out    = st.tx_line;
   assign transmit_line_pin_oe_out = cfg_in.spen;
   assign tx_buffer_empty_flag_out = tx_on && !st.hold_valid;
   assign shifter_empty_status_out = st.shifter_empty;
   assign rx_overrun_out           = st.overrun;

endmodule : asf_uart

//--- dv/asf_uart_props.sv
module asf_uart_props (
   input wire logic                  mclk_in,
   input wire logic                  resetn_in,
   input wire asf_pkg::asf_cfg_t     cfg_in,
   input wire logic                  tx_write_in,
   input wire logic [7:0]            tx_data_in,
   input wire logic                  tx_ninth_bit_in,
   input wire logic                  tx_buffer_empty_flag_out,
   input wire logic                  shifter_empty_status_out,
   input wire logic                  receive_line_pin_in,
   input wire logic                  transmit_line_pin_out,
   input wire logic                  transmit_line_pin_oe_out,
   input wire logic                  rx_valid_out,
   input wire asf_pkg::asf_rx_char_t rx_char_out,
   input wire logic                  rx_ready_in,
   input wire logic                  rx_overrun_out,
   input wire logic                  rx_overrun_clr_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // low run length of the transmit line
   // ----------
   logic        line_q;
   logic        rise;
   logic        tx_on;
   logic        rx_on;
   logic [31:0] run_len;
   logic [31:0] bit_len;
   assign tx_on   = cfg_in.spen & cfg_in.tx_en;
   assign rx_on   = cfg_in.spen & cfg_in.rx_en;
   assign rise    = transmit_line_pin_out & ~line_q;
   assign bit_len = 32'(cfg_in.brg16 ? cfg_in.brg_div : {8'h00, cfg_in.brg_div[7:0]})
                    * 32'h10 + 32'h10;
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         line_q  <= 1'b1;
         run_len <= 32'h0;
      end else begin
         line_q  <= transmit_line_pin_out;
         run_len <= (transmit_line_pin_out != line_q) ? 32'h1 : run_len + 32'h1;
      end
   end
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   a_oe_spen: assert property (transmit_line_pin_oe_out == cfg_in.spen)
      else $error("pin enable wrong");
   a_idle_mark: assert property (shifter_empty_status_out |-> transmit_line_pin_out)
      else $error("idle line not at mark");
   a_load_clears: assert property (tx_write_in && tx_on && shifter_empty_status_out
      |=> !shifter_empty_status_out) else $error("shifter empty not cleared");
   a_queue_flag: assert property (tx_write_in && tx_on && !shifter_empty_status_out
      && tx_buffer_empty_flag_out |=> !tx_buffer_empty_flag_out) else $error("no queueing");
   a_flag_off: assert property (!tx_on |-> !tx_buffer_empty_flag_out)
      else $error("buffer flag while disabled");
   a_bit_period: assert property (rise |-> (run_len % bit_len) == 32'h0)
      else $error("low run not whole bits");
   a_frame_low: assert property (rise |-> run_len <= bit_len * 32'hA)
      else $error("low run longer than a frame");
   a_rx_hold: assert property (rx_valid_out && !rx_ready_in && rx_on
      |=> rx_valid_out && $stable(rx_char_out)) else $error("rx head lost");
   a_ovr_sticky: assert property (rx_overrun_out && !rx_overrun_clr_in && rx_on
      |=> rx_overrun_out) else $error("overrun dropped");
   a_eight_bit: assert property (rx_valid_out && !cfg_in.nine_bit
      |-> !rx_char_out.data[8]) else $error("ninth bit in 8-bit mode");
endmodule : asf_uart_props

bind asf_uart asf_uart_props props_u (
   .mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_in(cfg_in), .tx_write_in(tx_write_in),
   .tx_data_in(tx_data_in), .tx_ninth_bit_in(tx_ninth_bit_in),
   .tx_buffer_empty_flag_out(tx_buffer_empty_flag_out),
   .shifter_empty_status_out(shifter_empty_status_out),
   .receive_line_pin_in(receive_line_pin_in), .transmit_line_pin_out(transmit_line_pin_out),
   .transmit_line_pin_oe_out(transmit_line_pin_oe_out), .rx_valid_out(rx_valid_out),
   .rx_char_out(rx_char_out), .rx_ready_in(rx_ready_in), .rx_overrun_out(rx_overrun_out),
   .rx_overrun_clr_in(rx_overrun_clr_in)
);

//--- dv/asf_remote.sv
module asf_remote (
   input  wire logic        mclk_in,
   input  wire logic [15:0] bit_clks_in,
   input  wire logic        nine_in,
   input  wire logic        line_in,
   output logic             line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] got_q[$];
   initial line_out = 1'b1;
   // sends one frame, then holds mark for stops bit times
   task automatic send_char(input logic [8:0] d, input logic stop_ok, input int stops);
      line_out = 1'b0;
      repeat (bit_clks_in) @(negedge mclk_in);
      for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
         line_out = d[i];
         repeat (bit_clks_in) @(negedge mclk_in);
      end
      line_out = stop_ok;
      repeat (bit_clks_in) @(negedge mclk_in);
      line_out = 1'b1;
      repeat (stops * bit_clks_in) @(negedge mclk_in);
   endtask : send_char
   // receiver samples each bit at its middle
   initial begin
      logic [9:0] c;
      forever begin
         @(negedge line_in);
         c = 10'h000;
         repeat (bit_clks_in / 16'h2) @(posedge mclk_in);
         for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
            repeat (bit_clks_in) @(posedge mclk_in);
            c[i] = line_in;
         end
         repeat (bit_clks_in) @(posedge mclk_in);
         c[9] = line_in;
         got_q.push_back(c);
      end
   end
endmodule : asf_remote

//--- dv/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  mclk_in, resetn_in, tx_write_in, tx_ninth_bit_in, buf_empty;
   logic                  shifter_empty, rx_line, tx_line, tx_oe, rx_valid, rx_ready;
   logic                  rx_overrun, ovr_clr;
   logic [7:0]            tx_data_in;
   logic [15:0]           bit_clks;
   asf_pkg::asf_cfg_t     cfg;
   asf_pkg::asf_rx_char_t rx_char;
   logic [9:0]            exp_tx_q[$], exp_rx_q[$];
   logic [18:0]           cfg_tab[4] = '{19'h10001, 19'h40302, 19'h70000, 19'h00100};
   int                    fails, checks_done, seed, cycles;

   asf_uart dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_in(cfg),
      .tx_write_in(tx_write_in), .tx_data_in(tx_data_in), .tx_ninth_bit_in(tx_ninth_bit_in),
      .tx_buffer_empty_flag_out(buf_empty), .shifter_empty_status_out(shifter_empty),
      .receive_line_pin_in(rx_line), .transmit_line_pin_out(tx_line),
      .transmit_line_pin_oe_out(tx_oe), .rx_valid_out(rx_valid), .rx_char_out(rx_char),
      .rx_ready_in(rx_ready), .rx_overrun_out(rx_overrun), .rx_overrun_clr_in(ovr_clr));
   asf_remote remote_u (.mclk_in(mclk_in), .bit_clks_in(bit_clks), .nine_in(cfg.nine_bit),
      .line_in(tx_line), .line_out(rx_line));

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         print_verdict();
      end
   end

   // ----------
   // tasks
   // ----------
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic write_char(input logic [8:0] d);
      tx_ninth_bit_in = d[8];
      tx_data_in = d[7:0];
      tx_write_in = 1'b1;
      @(negedge mclk_in);
      tx_write_in = 1'b0;
      @(negedge mclk_in);
   endtask : write_char
   task automatic pop_check(input logic [9:0] exp);
      check("rx_valid", 10'(rx_valid), 10'h1);
      check("rx_char", rx_char, exp);
      rx_ready = 1'b1;
      @(negedge mclk_in);
      rx_ready = 1'b0;
      @(negedge mclk_in);
   endtask : pop_check
   task automatic tx_part;
      logic [8:0] d;
      for (int i = 0; i < 3; i++) begin
         d = 9'($random(seed)) & (cfg.nine_bit ? 9'h1FF : 9'h0FF);
         exp_tx_q.push_back({1'b1, d});
         write_char(d);
         if (i == 0) check("shifter_empty", 10'(shifter_empty), 10'h0);
         if (i == 1) begin
            check("buf_empty", 10'(buf_empty), 10'h0);
            for (int n = 0; n < 20 * bit_clks && buf_empty !== 1'b1; n++) @(negedge mclk_in);
            check("shifter_busy", 10'(shifter_empty), 10'h0);
         end
      end
      for (int n = 0; n < 40 * bit_clks && shifter_empty !== 1'b1; n++) @(negedge mclk_in);
      check("shifter_done", 10'(shifter_empty), 10'h1);
   endtask : tx_part
   task automatic rx_part;
      logic [8:0] v;
      logic       ovr;
      ovr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         v = 9'($random(seed)) & (cfg.nine_bit ? 9'h1FF : 9'h0FF);
         if (cfg.addr_det) v[8] = (i != 1);
         remote_u.send_char(v, i != 3, i + 1);
         if (cfg.addr_det && !v[8]) continue;
         if (exp_rx_q.size() == 2) ovr = 1'b1;
         else exp_rx_q.push_back({i == 3, v});
         if (i == 2) begin
            check("overrun", 10'(rx_overrun), 10'(ovr));
            while (exp_rx_q.size() > 0) pop_check(exp_rx_q.pop_front());
            ovr_clr = 1'b1;
            @(negedge mclk_in);
            ovr_clr = 1'b0;
            @(negedge mclk_in);
            check("overrun_clr", 10'(rx_overrun), 10'h0);
         end
      end
      pop_check(exp_rx_q.pop_front());
      check("rx_drained", 10'(rx_valid), 10'h0);
   endtask : rx_part

   // ----------
   // main sequence
   // ----------
   initial begin
      seed = 32'h8074;
      cfg = {3'b111, cfg_tab[0]};
      bit_clks = 16'h20;
      {resetn_in, tx_write_in, tx_ninth_bit_in, tx_data_in, rx_ready, ovr_clr} = 13'h0000;
      repeat (4) @(negedge mclk_in);
      check("line_idle", 10'(tx_line), 10'h1);
      check("shifter_rst", 10'(shifter_empty), 10'h1);
      check("buf_rst", 10'(buf_empty), 10'h1);
      check("pin_oe", 10'(tx_oe), 10'h1);
      resetn_in = 1'b1;
      for (int k = 0; k < 4; k++) begin
         cfg = {3'b111, cfg_tab[k]};
         bit_clks = 16'h10 * ((cfg.brg16 ? cfg.brg_div : {8'h00, cfg.brg_div[7:0]}) + 16'h1);
         repeat (bit_clks) @(negedge mclk_in);
         fork
            tx_part();
            rx_part();
         join
         check("tx_count", 10'(remote_u.got_q.size()), 10'(exp_tx_q.size()));
         foreach (exp_tx_q[i]) check("tx_char", remote_u.got_q[i], exp_tx_q[i]);
         exp_tx_q.delete();
         remote_u.got_q.delete();
         $display("test %0d done", k);
      end
      cfg.tx_en = 1'b0;
      @(negedge mclk_in);
      check("buf_off", 10'(buf_empty), 10'h0);
      exp_rx_q.push_back({1'b0, 9'($random(seed)) & 9'h0FF});
      remote_u.send_char(exp_rx_q[0][8:0], 1'b1, 1);
      check("rx_alone_valid", 10'(rx_valid), 10'h1);
      check("rx_alone", rx_char, exp_rx_q.pop_front());
      cfg.rx_en = 1'b0;
      @(negedge mclk_in);
      check("rx_flushed", 10'(rx_valid), 10'h0);
      cfg.spen = 1'b0;
      @(negedge mclk_in);
      check("pin_off", 10'(tx_oe), 10'h0);
      $display("test %0d done", 4);
      print_verdict();
   end
endmodule : tb
